// ==== rtl/scg_pkg.sv ====
package scg_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [11:0] OFF_SYSCFG = 12'h000;
    localparam logic [11:0] OFF_PLLCFG = 12'h004;
    localparam logic [11:0] OFF_PRESC = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00c;

    // source select field encodings
    localparam logic [1:0] SEL_WAKEUP = 2'h0;
    localparam logic [1:0] SEL_RSVD = 2'h1;
    localparam logic [1:0] SEL_PLL = 2'h2;
    localparam logic [1:0] SEL_DIRECT = 2'h3;

    // internal generation modes, also index of the mode clock vector
    typedef enum logic [1:0] {
        MODE_WU = 2'h0,
        MODE_PRE = 2'h1,
        MODE_PLL = 2'h2,
        MODE_DIR = 2'h3
    } scg_mode_e;

    // index of each synchronised source pin
    localparam int SRC_WU = 0;
    localparam int SRC_XTAL = 1;
    localparam int SRC_INT = 2;
    localparam int SRC_DIR = 3;
    localparam int SRC_N = 4;

    localparam int K1_W = 10;
    localparam int CNT_W = 10;
    localparam int ACC_W = 16;
    localparam int VCNT_W = 10;

    typedef struct packed {
        logic [8:0] rsvd;
        logic [6:0] k2_field;
        logic [7:0] n_field;
        logic [3:0] p_field;
        logic ref_internal;
        logic [1:0] band;
        logic bypass;
    } scg_pll_cfg_s;

    typedef struct packed {
        logic [26:0] rsvd;
        logic pll_locked;
        logic switch_busy;
        logic [1:0] active_mode;
    } scg_status_s;

    localparam logic [1:0] SYSCFG_RST = SEL_WAKEUP;
    localparam scg_pll_cfg_s PLLCFG_RST = '{
        rsvd: 9'h000, k2_field: 7'h00, n_field: 8'h00, p_field: 4'h0,
        ref_internal: 1'b0, band: 2'h0, bypass: 1'b1};
    localparam logic [K1_W-1:0] PRESC_RST = 10'h000;

    // vco band limits on the phase step of the digital oscillator
    localparam logic [1:0] BAND0 = 2'h0;
    localparam logic [ACC_W-1:0] BAND0_MIN = 16'h0800;
    localparam logic [ACC_W-1:0] BAND0_MAX = 16'h4000;
    localparam logic [ACC_W-1:0] BAND1_MIN = 16'h1000;
    localparam logic [ACC_W-1:0] BAND1_MAX = 16'h7000;

    typedef enum logic [1:0] {
        SW_RUN = 2'b00,
        SW_HOLD = 2'b01,
        SW_ARM = 2'b11
    } scg_sw_e;

endpackage

// ==== rtl/scg_clock_gen.sv ====
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - select 11 drives the system clock straight from the direct input.
// - in direct drive the output keeps the input duty cycle unchanged.
// - crystal bypass with a divide factor of one behaves as direct drive.
// - select 10 with bypass set divides the oscillator by prescaler plus one.
// - a prescaler factor of one passes the oscillator level and duty through.
// - the largest prescaler factor is 1024, the slowest selectable clock.
// - select 10 with bypass clear runs the pll and takes its output.
// - pll factor is N over P times K2, each being its field plus one.
// - the pll reference is either the crystal input or the internal source.
// - the pll moves its frequency one small step per compare, jumping only to clamp the step into the band or to restart it at the band minimum.
// - the system clock in pll mode is the vco divided by K2.
// - band 00 and 01 set the vco range, band 1X is reserved.
// - select 00 takes the system clock from the wakeup source.
module scg_clock_gen (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // clock source pins
    input wire logic wakeup_clock,
    input wire logic crystal_input,
    input wire logic internal_clock,
    input wire logic direct_clock_input,
    // generated clock
    output logic sys_clk
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [scg_pkg::CNT_W-1:0] div_next(
        input logic [scg_pkg::CNT_W-1:0] cnt,
        input logic [scg_pkg::CNT_W-1:0] lim);
        return (cnt >= lim) ? '0 : cnt + 10'h001;
    endfunction

    // high for ceil(k/2) source periods, so odd factors lean high
    function automatic logic div_high(
        input logic [scg_pkg::CNT_W-1:0] cnt,
        input logic [scg_pkg::CNT_W-1:0] lim);
        logic [scg_pkg::CNT_W:0] half;
        half = ({1'b0, lim} + 11'h002) >> 1;
        return {1'b0, cnt} < half;
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [scg_pkg::SRC_N-1:0] meta_reg;
    logic [scg_pkg::SRC_N-1:0] sync_reg;
    logic [scg_pkg::SRC_N-1:0] last_reg;
    wire [scg_pkg::SRC_N-1:0] pins = {direct_clock_input, internal_clock,
        crystal_input, wakeup_clock};
    wire [scg_pkg::SRC_N-1:0] rise = sync_reg & ~last_reg;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= pins;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [1:0] syscfg_reg;
    scg_pkg::scg_pll_cfg_s pllcfg_reg;
    logic [scg_pkg::K1_W-1:0] presc_reg;
    scg_pkg::scg_status_s status;
    scg_pkg::scg_pll_cfg_s wr_pll;

    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire hit_sys = paddr == scg_pkg::OFF_SYSCFG;
    wire hit_pll = paddr == scg_pkg::OFF_PLLCFG;
    wire hit_pre = paddr == scg_pkg::OFF_PRESC;
    wire hit_sta = paddr == scg_pkg::OFF_STATUS;
    wire mapped = hit_sys | hit_pll | hit_pre | hit_sta;
    assign wr_pll = scg_pkg::scg_pll_cfg_s'(pwdata);
    wire sel_ok = pwdata[1:0] != scg_pkg::SEL_RSVD;
    wire band_ok = ~wr_pll.band[1];
    wire [31:0] rd_mux = hit_sys ? {30'h0, syscfg_reg} :
        hit_pll ? {9'h000, pllcfg_reg[22:0]} :
        hit_pre ? {22'h0, presc_reg} :
        hit_sta ? 32'(status) : '0;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            syscfg_reg <= scg_pkg::SYSCFG_RST;
            pllcfg_reg <= scg_pkg::PLLCFG_RST;
            presc_reg <= scg_pkg::PRESC_RST;
        end else if (access && pwrite) begin
            if (hit_sys && sel_ok) begin
                syscfg_reg <= pwdata[1:0];
            end
            if (hit_pll && band_ok) begin
                pllcfg_reg <= {9'h000, wr_pll[22:0]};
            end
            if (hit_pre) begin
                presc_reg <= pwdata[scg_pkg::K1_W-1:0];
            end
        end
    end

    // answer in the first access cycle; pready is low in setup
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                prdata <= pwrite ? '0 : rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------
    // requested mode
    // ------------------------------------------------------------------
    scg_pkg::scg_mode_e req_mode;
    scg_pkg::scg_mode_e cur_mode_reg;
    assign req_mode = (syscfg_reg == scg_pkg::SEL_DIRECT) ? scg_pkg::MODE_DIR :
        (syscfg_reg == scg_pkg::SEL_WAKEUP) ? scg_pkg::MODE_WU :
        pllcfg_reg.bypass ? scg_pkg::MODE_PRE : scg_pkg::MODE_PLL;

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    logic [scg_pkg::CNT_W-1:0] k1_cnt_reg;
    wire osc_lvl = pllcfg_reg.ref_internal ? sync_reg[scg_pkg::SRC_INT] :
        sync_reg[scg_pkg::SRC_XTAL];
    wire osc_rise = pllcfg_reg.ref_internal ? rise[scg_pkg::SRC_INT] :
        rise[scg_pkg::SRC_XTAL];
    wire pre_clk = (presc_reg == '0) ? osc_lvl :
        div_high(k1_cnt_reg, presc_reg);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            k1_cnt_reg <= '0;
        end else if (osc_rise) begin
            k1_cnt_reg <= div_next(k1_cnt_reg, presc_reg);
        end
    end

    // ------------------------------------------------------------------
    // digital pll: phase accumulator as vco, frequency-locked to N times ref/P
    // ------------------------------------------------------------------
    logic [scg_pkg::ACC_W-1:0] acc_reg;
    logic [scg_pkg::ACC_W-1:0] step_reg;
    logic vco_reg;
    logic [scg_pkg::CNT_W-1:0] p_cnt_reg;
    logic [scg_pkg::CNT_W-1:0] k2_cnt_reg;
    logic [scg_pkg::VCNT_W-1:0] vcnt_reg;
    logic lock_reg;

    wire pll_on = (req_mode == scg_pkg::MODE_PLL) ||
        (cur_mode_reg == scg_pkg::MODE_PLL);
    wire [scg_pkg::CNT_W-1:0] p_lim = {6'h00, pllcfg_reg.p_field};
    wire [scg_pkg::CNT_W-1:0] k2_lim = {3'h0, pllcfg_reg.k2_field};
    wire [scg_pkg::VCNT_W-1:0] n_tgt = {2'h0, pllcfg_reg.n_field} + 10'h001;
    wire [scg_pkg::ACC_W:0] acc_sum = {1'b0, acc_reg} + {1'b0, step_reg};
    wire vco_rise = acc_sum[scg_pkg::ACC_W] & ~vco_reg;
    wire win_end = osc_rise && (p_cnt_reg >= p_lim);
    wire in_band0 = pllcfg_reg.band == scg_pkg::BAND0;
    wire [scg_pkg::ACC_W-1:0] step_min = in_band0 ? scg_pkg::BAND0_MIN :
        scg_pkg::BAND1_MIN;
    wire [scg_pkg::ACC_W-1:0] step_max = in_band0 ? scg_pkg::BAND0_MAX :
        scg_pkg::BAND1_MAX;
    wire pll_clk = (k2_lim == '0) ? vco_reg :
        div_high(k2_cnt_reg, k2_lim);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            acc_reg <= '0;
            step_reg <= scg_pkg::BAND0_MIN;
            vco_reg <= 1'b0;
            p_cnt_reg <= '0;
            k2_cnt_reg <= '0;
            vcnt_reg <= '0;
            lock_reg <= 1'b0;
        end else if (!pll_on) begin
            step_reg <= step_min;
            lock_reg <= 1'b0;
            vcnt_reg <= '0;
        end else begin
            acc_reg <= acc_sum[scg_pkg::ACC_W-1:0];
            if (acc_sum[scg_pkg::ACC_W]) begin
                vco_reg <= ~vco_reg;
            end
            if (vco_rise) begin
                k2_cnt_reg <= div_next(k2_cnt_reg, k2_lim);
            end
            if (osc_rise) begin
                p_cnt_reg <= div_next(p_cnt_reg, p_lim);
            end
            if (win_end) begin
                // one lsb per window keeps the frequency slewing smoothly
                // a rise on the window edge opens the next window
                vcnt_reg <= vco_rise ? 10'h001 : 10'h000;
                lock_reg <= vcnt_reg == n_tgt;
                if (step_reg < step_min) begin
                    step_reg <= step_min;
                end else if (step_reg > step_max) begin
                    step_reg <= step_max;
                end else if (vcnt_reg < n_tgt && step_reg < step_max) begin
                    step_reg <= step_reg + 16'h0001;
                end else if (vcnt_reg > n_tgt && step_reg > step_min) begin
                    step_reg <= step_reg - 16'h0001;
                end
            end else if (vco_rise && vcnt_reg != '1) begin
                vcnt_reg <= vcnt_reg + 10'h001;
            end
        end
    end

    // ------------------------------------------------------------------
    // glitch-free source switch
    // ------------------------------------------------------------------
    scg_pkg::scg_sw_e sw_reg;
    scg_pkg::scg_sw_e sw_next;
    wire [3:0] mode_clk = {sync_reg[scg_pkg::SRC_DIR], pll_clk, pre_clk,
        sync_reg[scg_pkg::SRC_WU]};
    wire cur_clk = mode_clk[cur_mode_reg];
    wire req_clk = mode_clk[req_mode];

    always_comb begin
        sw_next = sw_reg;
        case (sw_reg)
            scg_pkg::SW_RUN: begin
                if (req_mode != cur_mode_reg) begin
                    sw_next = scg_pkg::SW_HOLD;
                end
            end
            scg_pkg::SW_HOLD: begin
                if (!cur_clk) begin
                    sw_next = scg_pkg::SW_ARM;
                end
            end
            scg_pkg::SW_ARM: begin
                if (!cur_clk) begin
                    sw_next = scg_pkg::SW_RUN;
                end
            end
            default: sw_next = scg_pkg::SW_RUN;
        endcase
    end

    // output is parked low across a change and only released when the
    // new source is itself low, so its next high phase is a whole one
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sw_reg <= scg_pkg::SW_RUN;
            cur_mode_reg <= scg_pkg::MODE_WU;
            sys_clk <= 1'b0;
        end else begin
            sw_reg <= sw_next;
            case (sw_reg)
                scg_pkg::SW_RUN: sys_clk <= cur_clk;
                scg_pkg::SW_HOLD: begin
                    if (!cur_clk) begin
                        sys_clk <= 1'b0;
                        cur_mode_reg <= req_mode;
                    end
                end
                default: sys_clk <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // status
    // ------------------------------------------------------------------
    assign status = '{rsvd: 27'h0, pll_locked: lock_reg,
        switch_busy: sw_reg != scg_pkg::SW_RUN, active_mode: cur_mode_reg};

endmodule

// ==== bench/scg_src_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// source clocks: free running, edges kept 13 ns off the mclk edge
// ----------------------------------------------------------------------
module scg_src_model (
    // source clock pins
    output logic wakeup_clock,
    output logic crystal_input,
    output logic internal_clock,
    output logic direct_clock_input
);
    // an oscillator never stops, so no idle level is modelled
    initial begin
        wakeup_clock = 1'b0;
        crystal_input = 1'b0;
        internal_clock = 1'b0;
        direct_clock_input = 1'b0;
        #13;
        fork
            forever #640 wakeup_clock = ~wakeup_clock;
            forever #200 crystal_input = ~crystal_input;
            forever #240 internal_clock = ~internal_clock;
            // uneven duty so a reshaped output is seen
            forever begin
                direct_clock_input = 1'b1;
                #200;
                direct_clock_input = 1'b0;
                #360;
            end
        join
    end
endmodule

// ==== bench/scg_clock_gen_assertions.sv ====
`timescale 1ns/1ps
module scg_clock_gen_assertions (
    // clock and reset
    input wire logic mclk,
    input wire logic arst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sources and output
    input wire logic wakeup_clock,
    input wire logic crystal_input,
    input wire logic internal_clock,
    input wire logic direct_clock_input,
    input wire logic sys_clk
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);
    // ------------------------------------------------------------------
    // tracking of the accepted source select
    // ------------------------------------------------------------------
    logic [1:0] sel_q;
    logic [7:0] cnt;
    wire setup = psel && !penable;
    wire acc = psel && penable && pready && pwrite && paddr == 12'h000
        && pwdata[1:0] != 2'h1;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sel_q <= 2'h0;
            cnt <= 8'h00;
        end else if (acc) begin
            sel_q <= pwdata[1:0];
            cnt <= 8'h00;
        end else if (cnt != 8'hff) begin
            cnt <= cnt + 8'h01;
        end
    end
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    property p_ready;
        setup |=> pready;
    endproperty
    property p_pulse;
        pready |=> !pready;
    endproperty
    property p_err;
        pslverr |-> pready;
    endproperty
    property p_unmap;
        setup && paddr > scg_pkg::OFF_STATUS |=> pslverr;
    endproperty
    property p_hi;
        $rose(sys_clk) |=> sys_clk [*3];
    endproperty
    property p_lo;
        $fell(sys_clk) |=> !sys_clk [*3];
    endproperty
    // settled modes: long after the last select write
    property p_dir;
        sel_q == 2'h3 && cnt == 8'hff |-> sys_clk ==
            $past(direct_clock_input, 3) || sys_clk == $past(direct_clock_input, 4);
    endproperty
    property p_wu;
        sel_q == 2'h0 && cnt == 8'hff |-> sys_clk ==
            $past(wakeup_clock, 3) || sys_clk == $past(wakeup_clock, 4);
    endproperty
    a_ready: assert property (p_ready) else $error("no ready");
    a_pulse: assert property (p_pulse) else $error("long ready");
    a_err: assert property (p_err) else $error("stray error");
    a_unmap: assert property (p_unmap) else $error("no error");
    a_hi: assert property (p_hi) else $error("short high");
    a_lo: assert property (p_lo) else $error("short low");
    a_dir: assert property (p_dir) else $error("direct off");
    a_wu: assert property (p_wu) else $error("wakeup off");
    c_dir: cover property (sel_q == 2'h3 && cnt == 8'hff);
    c_err: cover property (pslverr);
    c_gen: cover property (sel_q == 2'h2 && $rose(sys_clk));
endmodule

bind scg_clock_gen scg_clock_gen_assertions u_chk (
    .mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .wakeup_clock, .crystal_input, .internal_clock,
    .direct_clock_input, .sys_clk
);

// ==== bench/system_clock_generation_tb.sv ====
`timescale 1ns/1ps
module system_clock_generation_tb;
    logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, sys_clk;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic wu, xt, ic, dc, err;
    int n_fail, num_checks, seed, hi, lo, n;
    scg_clock_gen dut (.mclk(mclk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wakeup_clock(wu), .crystal_input(xt), .internal_clock(ic),
        .direct_clock_input(dc), .sys_clk(sys_clk));
    scg_src_model src (.wakeup_clock(wu), .crystal_input(xt),
        .internal_clock(ic), .direct_clock_input(dc));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // one apb transfer, released only after pready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16) n_fail++;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, exp);
        apb(1'b0, a, 32'h0);
        check("read", rd & m, exp);
    endtask
    // third whole pulse after a change, in mclk cycles
    task automatic measure();
        n = 0;
        repeat (2) begin
            while (sys_clk !== 1'b0 && n < 9000) begin
                @(posedge mclk);
                n++;
            end
            while (sys_clk !== 1'b1 && n < 9000) begin
                @(posedge mclk);
                n++;
            end
            hi = 0;
            lo = 0;
            while (sys_clk === 1'b1 && hi < 900) begin
                @(posedge mclk);
                hi++;
            end
            while (sys_clk === 1'b0 && lo < 900) begin
                @(posedge mclk);
                lo++;
            end
        end
    endtask
    // divided clocks stay high for ceil(k/2) source periods
    function automatic logic [31:0] exp_hi(int k, int per);
        return (k == 1) ? per / 2 : ((k + 1) / 2) * per;
    endfunction
    function automatic logic [31:0] exp_lo(int k, int per);
        return (k == 1) ? per / 2 : (k / 2) * per;
    endfunction
    initial begin
        seed = 69;
        n_fail = 0;
        num_checks = 0;
        arst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        rdchk(scg_pkg::OFF_SYSCFG, 32'hffffffff, 32'h0);
        rdchk(scg_pkg::OFF_PLLCFG, 32'hffffffff, 32'h1);
        rdchk(scg_pkg::OFF_PRESC, 32'hffffffff, 32'h0);
        rdchk(scg_pkg::OFF_STATUS, 32'h3, 32'h0);
        apb(1'b1, scg_pkg::OFF_SYSCFG, 32'h1);
        rdchk(scg_pkg::OFF_SYSCFG, 32'h3, 32'h0);
        apb(1'b1, scg_pkg::OFF_PLLCFG, 32'h5);
        rdchk(scg_pkg::OFF_PLLCFG, 32'hffffffff, 32'h1);
        apb(1'b0, 12'h010 + 12'($random(seed) & 32'hf0), 32'h0);
        check("slverr", {31'h0, err}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            d = $random(seed) & 32'h007ffffb;
            apb(1'b1, scg_pkg::OFF_PLLCFG, d);
            rdchk(scg_pkg::OFF_PLLCFG, 32'hffffffff, d);
        end
        apb(1'b1, scg_pkg::OFF_PRESC, 32'h3ff);
        rdchk(scg_pkg::OFF_PRESC, 32'hffffffff, 32'h3ff);
        $display("test registers done");
        apb(1'b1, scg_pkg::OFF_SYSCFG, 32'h3);
        measure();
        check("direct high", hi, 32'd5);
        check("direct low", lo, 32'd9);
        rdchk(scg_pkg::OFF_STATUS, 32'h3, 32'h3);
        $display("test direct done");
        for (int i = 0; i < 3; i++) begin
            // park on wakeup, fields, then the select
            // divide factor grows one step at a time
            apb(1'b1, scg_pkg::OFF_SYSCFG, 32'h0);
            repeat (80) @(posedge mclk);
            apb(1'b1, scg_pkg::OFF_PLLCFG, (i == 2) ? 32'h9 : 32'h1);
            apb(1'b1, scg_pkg::OFF_PRESC, 32'(i));
            apb(1'b1, scg_pkg::OFF_SYSCFG, 32'h2);
            measure();
            check("pre high", hi, exp_hi(i + 1, (i == 2) ? 12 : 10));
            check("pre low", lo, exp_lo(i + 1, (i == 2) ? 12 : 10));
        end
        rdchk(scg_pkg::OFF_STATUS, 32'h3, 32'h1);
        $display("test prescaler done");
        apb(1'b1, scg_pkg::OFF_SYSCFG, 32'h0);
        repeat (80) @(posedge mclk);
        apb(1'b1, scg_pkg::OFF_PLLCFG, 32'h000104f2);
        apb(1'b1, scg_pkg::OFF_SYSCFG, 32'h2);
        rd = 32'h0;
        for (int i = 0; i < 12000 && rd[3] !== 1'b1; i++)
            apb(1'b0, scg_pkg::OFF_STATUS, 32'h0);
        check("locked", rd & 32'hb, 32'ha);
        measure();
        // ten cycle crystal, p 16, n 5, k2 2, band 1 gives sixty-four
        check("pll period", 32'(hi + lo > 61 && hi + lo < 67),
            32'h1);
        $display("test pll done");
        apb(1'b1, scg_pkg::OFF_SYSCFG, 32'h0);
        measure();
        check("wakeup high", hi, 32'd16);
        check("wakeup low", lo, 32'd16);
        $display("test wakeup done");
        complete_run();
    end
    initial begin
        #4000000;
        n_fail++;
        complete_run();
    end
endmodule
